/* xprio_defs.svh */
// Constants for the extended interrupt priority register pair.
// Assumes inclusion by bare name from the package and design modules.
`ifndef XPRIO_DEFS_SVH
`define XPRIO_DEFS_SVH
`define XPRIO_PAGE 8'h10
`define XPRIO_LOW_ADDR 8'hed
`define XPRIO_HIGH_ADDR 8'hf6
`define XPRIO_RESET 8'h00
`define XPRIO_FIELD_MASK 8'h1f
`define XPRIO_NUM_SRC 5
`define XPRIO_BIT_CLU0 4
`define XPRIO_BIT_TMR5 3
`define XPRIO_BIT_TMR4 2
`define XPRIO_BIT_TWS 1
`define XPRIO_BIT_SER1 0
`endif

/* xprio_pkg.sv */
// Types for the extended interrupt priority register pair.
// Assumes xprio_defs.svh is on the include path.
`include "xprio_defs.svh"
package xprio_pkg;
  typedef logic [7:0] xprio_byte_t;
  typedef logic [1:0] xprio_level_t;
  typedef enum logic [1:0] {
    XPRIO_SEL_NONE = 2'b01,
    XPRIO_SEL_REG = 2'b10
  } xprio_sel_e;
endpackage

/* xprio_reg8.sv */
// One 8-bit priority register with a writable field.
// Assumes single-cycle write strobe from the decoder.
`include "xprio_defs.svh"
module xprio_reg8
  import xprio_pkg::*;
#(
  parameter logic [7:0] FIELD_MASK = `XPRIO_FIELD_MASK,
  parameter logic [7:0] RESET_VAL = `XPRIO_RESET
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wr_in,
  input wire logic [7:0] wdata_in,
  output logic [7:0] value_out
);
  xprio_byte_t data_q;
  xprio_byte_t data_d;
  // Writes load reserved bits as zero through FIELD_MASK
  assign data_d = wr_in ? (wdata_in & FIELD_MASK) : data_q;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      data_q <= RESET_VAL;
    end else begin
      data_q <= data_d;
    end
  end
  assign value_out = data_q;
endmodule // xprio_reg8

/* xprio_decode.sv */
// Special-function-register address decode for the priority pair.
// Assumes page, address and strobes are synchronous to the core clock.
`include "xprio_defs.svh"
module xprio_decode
  import xprio_pkg::*;
(
  input wire logic [7:0] page_in,
  input wire logic [7:0] addr_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic low_wr_out,
  output logic high_wr_out,
  output logic low_sel_out,
  output logic high_sel_out
);
  logic page_hit;
  assign page_hit = (page_in == `XPRIO_PAGE);
  assign low_sel_out = page_hit && (addr_in == `XPRIO_LOW_ADDR);
  assign high_sel_out = page_hit && (addr_in == `XPRIO_HIGH_ADDR);
  assign low_wr_out = low_sel_out && wr_in && !rd_in;
  assign high_wr_out = high_sel_out && wr_in && !rd_in;
endmodule // xprio_decode

/* xprio_regs.sv */
// Extended interrupt priority register pair and per-source levels.
// Assumes the core drives page, address and strobes from clk_in.
//
// Summary of operation
// - Low bit 4 is logic unit priority LSB
// - Low bit 3 is timer 5 priority LSB
// - Low bit 2 is timer 4 priority LSB
// - Low bit 1 is two-wire slave LSB
// - Low bit 0 is serial port 1 LSB
// - High bit 4 is logic unit priority MSB
// - High bit 3 is timer 5 priority MSB
// - High bit 2 is timer 4 priority MSB
// - High bit 1 is two-wire slave MSB
// - High bit 0 is serial port 1 MSB
// - Low register at page 10, address ed
// - High register at page 10, address f6
`include "xprio_defs.svh"
module xprio_regs
  import xprio_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] sfr_page_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  output logic sfr_hit_out,
  output logic [7:0] irq_priority_low_bits_2_out,
  output logic [7:0] irq_priority_high_bits_2_out,
  output logic [1:0] logic_unit0_level_out,
  output logic [1:0] timer5_level_out,
  output logic [1:0] timer4_level_out,
  output logic [1:0] twowire_slave_level_out,
  output logic [1:0] serial_port1_level_out
);
  logic low_wr;
  logic high_wr;
  logic low_sel;
  logic high_sel;
  xprio_byte_t low_val;
  xprio_byte_t high_val;
  xprio_byte_t rdata_q;
  xprio_byte_t rdata_d;
  xprio_sel_e sel;

  xprio_decode u_dec (
    .page_in(sfr_page_in),
    .addr_in(sfr_addr_in),
    .wr_in(sfr_wr_in),
    .rd_in(sfr_rd_in),
    .low_wr_out(low_wr),
    .high_wr_out(high_wr),
    .low_sel_out(low_sel),
    .high_sel_out(high_sel)
  );

  xprio_reg8 u_low (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_in(low_wr),
    .wdata_in(sfr_wdata_in),
    .value_out(low_val)
  );

  xprio_reg8 u_high (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wr_in(high_wr),
    .wdata_in(sfr_wdata_in),
    .value_out(high_val)
  );

  function automatic xprio_level_t level_of(input xprio_byte_t hi,
                                            input xprio_byte_t lo,
                                            input int idx);
    level_of = {hi[idx], lo[idx]};
  endfunction

  assign logic_unit0_level_out =
    level_of(high_val, low_val, `XPRIO_BIT_CLU0);
  assign timer5_level_out =
    level_of(high_val, low_val, `XPRIO_BIT_TMR5);
  assign timer4_level_out =
    level_of(high_val, low_val, `XPRIO_BIT_TMR4);
  assign twowire_slave_level_out =
    level_of(high_val, low_val, `XPRIO_BIT_TWS);
  assign serial_port1_level_out =
    level_of(high_val, low_val, `XPRIO_BIT_SER1);

  assign irq_priority_low_bits_2_out = low_val;
  assign irq_priority_high_bits_2_out = high_val;

  // Read data registered one cycle after the read strobe
  assign sel = (low_sel || high_sel) ? XPRIO_SEL_REG : XPRIO_SEL_NONE;
  always_comb begin
    rdata_d = 8'h00;
    unique case (sel)
      XPRIO_SEL_REG: rdata_d = low_sel ? low_val : high_val;
      XPRIO_SEL_NONE: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd_in) begin
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata_out = rdata_q;
  assign sfr_hit_out = low_sel || high_sel;

  // Assertions
  property p_low_write;
    @(posedge clk_in) disable iff (rst_in)
      (sfr_wr_in && !sfr_rd_in && sfr_page_in == `XPRIO_PAGE &&
       sfr_addr_in == `XPRIO_LOW_ADDR) |=>
        (low_val == ($past(sfr_wdata_in) & `XPRIO_FIELD_MASK));
  endproperty
  a_low_write: assert property (p_low_write)
    else $error("low register write not stored");

  property p_high_write;
    @(posedge clk_in) disable iff (rst_in)
      (sfr_wr_in && !sfr_rd_in && sfr_page_in == `XPRIO_PAGE &&
       sfr_addr_in == `XPRIO_HIGH_ADDR) |=>
        (high_val == ($past(sfr_wdata_in) & `XPRIO_FIELD_MASK));
  endproperty
  a_high_write: assert property (p_high_write)
    else $error("high register write not stored");

  property p_wrong_page;
    @(posedge clk_in) disable iff (rst_in)
      (sfr_page_in != `XPRIO_PAGE) |=>
        ($stable(low_val) && $stable(high_val));
  endproperty
  a_wrong_page: assert property (p_wrong_page)
    else $error("write on other page changed a register");

  property p_reserved_zero;
    @(posedge clk_in) disable iff (rst_in)
      (low_val[7:5] == 3'h0) && (high_val[7:5] == 3'h0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits not zero");

  property p_clu0_level;
    @(posedge clk_in) disable iff (rst_in)
      logic_unit0_level_out == {high_val[4], low_val[4]};
  endproperty
  a_clu0_level: assert property (p_clu0_level)
    else $error("logic unit level mismatch");

  property p_tmr5_level;
    @(posedge clk_in) disable iff (rst_in)
      timer5_level_out == {high_val[3], low_val[3]};
  endproperty
  a_tmr5_level: assert property (p_tmr5_level)
    else $error("timer 5 level mismatch");

  property p_tmr4_level;
    @(posedge clk_in) disable iff (rst_in)
      timer4_level_out == {high_val[2], low_val[2]};
  endproperty
  a_tmr4_level: assert property (p_tmr4_level)
    else $error("timer 4 level mismatch");

  property p_tws_level;
    @(posedge clk_in) disable iff (rst_in)
      twowire_slave_level_out == {high_val[1], low_val[1]};
  endproperty
  a_tws_level: assert property (p_tws_level)
    else $error("two-wire slave level mismatch");

  property p_ser1_level;
    @(posedge clk_in) disable iff (rst_in)
      serial_port1_level_out == {high_val[0], low_val[0]};
  endproperty
  a_ser1_level: assert property (p_ser1_level)
    else $error("serial port 1 level mismatch");

  sequence s_write_low_all;
    sfr_wr_in && !sfr_rd_in && sfr_page_in == `XPRIO_PAGE &&
      sfr_addr_in == `XPRIO_LOW_ADDR && sfr_wdata_in == 8'hff;
  endsequence
  sequence s_read_low;
    sfr_rd_in && !sfr_wr_in && sfr_page_in == `XPRIO_PAGE &&
      sfr_addr_in == `XPRIO_LOW_ADDR;
  endsequence
  property p_write_then_read;
    @(posedge clk_in) disable iff (rst_in)
      s_write_low_all ##1 s_read_low |=>
        (sfr_rdata_out == `XPRIO_FIELD_MASK);
  endproperty
  a_write_then_read: assert property (p_write_then_read)
    else $error("readback of low register wrong");

  // Hold, read path, reset and level write checks
  sequence s_low_wr_req;
    sfr_wr_in && !sfr_rd_in && sfr_page_in == `XPRIO_PAGE &&
      sfr_addr_in == `XPRIO_LOW_ADDR;
  endsequence
  sequence s_high_wr_req;
    sfr_wr_in && !sfr_rd_in && sfr_page_in == `XPRIO_PAGE &&
      sfr_addr_in == `XPRIO_HIGH_ADDR;
  endsequence
  sequence s_high_rd_req;
    sfr_rd_in && !sfr_wr_in && sfr_page_in == `XPRIO_PAGE &&
      sfr_addr_in == `XPRIO_HIGH_ADDR;
  endsequence

  property p_low_hold;
    @(posedge clk_in) disable iff (rst_in)
      !(sfr_wr_in && !sfr_rd_in && sfr_page_in == `XPRIO_PAGE &&
        sfr_addr_in == `XPRIO_LOW_ADDR) |=> $stable(low_val);
  endproperty
  a_low_hold: assert property (p_low_hold)
    else $error("low register changed without a write");

  property p_high_hold;
    @(posedge clk_in) disable iff (rst_in)
      !(sfr_wr_in && !sfr_rd_in && sfr_page_in == `XPRIO_PAGE &&
        sfr_addr_in == `XPRIO_HIGH_ADDR) |=> $stable(high_val);
  endproperty
  a_high_hold: assert property (p_high_hold)
    else $error("high register changed without a write");

  property p_low_wr_spares_high;
    @(posedge clk_in) disable iff (rst_in)
      s_low_wr_req |=> $stable(high_val);
  endproperty
  a_low_wr_spares_high: assert property (p_low_wr_spares_high)
    else $error("low register write disturbed high register");

  property p_high_wr_spares_low;
    @(posedge clk_in) disable iff (rst_in)
      s_high_wr_req |=> $stable(low_val);
  endproperty
  a_high_wr_spares_low: assert property (p_high_wr_spares_low)
    else $error("high register write disturbed low register");

  property p_both_strobes;
    @(posedge clk_in) disable iff (rst_in)
      (sfr_wr_in && sfr_rd_in) |=> ($stable(low_val) && $stable(high_val));
  endproperty
  a_both_strobes: assert property (p_both_strobes)
    else $error("write with read strobe changed a register");

  property p_read_low;
    @(posedge clk_in) disable iff (rst_in)
      (sfr_rd_in && sfr_page_in == `XPRIO_PAGE &&
       sfr_addr_in == `XPRIO_LOW_ADDR) |=> (sfr_rdata_out == $past(low_val));
  endproperty
  a_read_low: assert property (p_read_low)
    else $error("low register read data wrong");

  property p_read_high;
    @(posedge clk_in) disable iff (rst_in)
      (sfr_rd_in && sfr_page_in == `XPRIO_PAGE &&
       sfr_addr_in == `XPRIO_HIGH_ADDR) |=>
        (sfr_rdata_out == $past(high_val));
  endproperty
  a_read_high: assert property (p_read_high)
    else $error("high register read data wrong");

  property p_read_unmapped;
    @(posedge clk_in) disable iff (rst_in)
      sfr_rd_in && !(sfr_page_in == `XPRIO_PAGE &&
        (sfr_addr_in == `XPRIO_LOW_ADDR ||
         sfr_addr_in == `XPRIO_HIGH_ADDR)) |=> (sfr_rdata_out == 8'h00);
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped read returned nonzero data");

  property p_rdata_hold;
    @(posedge clk_in) disable iff (rst_in)
      !sfr_rd_in |=> $stable(sfr_rdata_out);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read strobe");

  property p_hit_decode;
    @(posedge clk_in) disable iff (rst_in)
      sfr_hit_out == (sfr_page_in == `XPRIO_PAGE &&
        (sfr_addr_in == `XPRIO_LOW_ADDR ||
         sfr_addr_in == `XPRIO_HIGH_ADDR));
  endproperty
  a_hit_decode: assert property (p_hit_decode)
    else $error("register hit flag wrong");

  property p_reset_clear;
    @(posedge clk_in)
      $fell(rst_in) |-> (low_val == `XPRIO_RESET &&
        high_val == `XPRIO_RESET && sfr_rdata_out == 8'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("registers not cleared by reset");

  property p_high_write_then_read;
    @(posedge clk_in) disable iff (rst_in)
      s_high_wr_req ##1 s_high_rd_req |=>
        (sfr_rdata_out == ($past(sfr_wdata_in, 2) & `XPRIO_FIELD_MASK));
  endproperty
  a_high_write_then_read: assert property (p_high_write_then_read)
    else $error("readback of high register wrong");

  property p_ser1_lsb_write;
    @(posedge clk_in) disable iff (rst_in)
      s_low_wr_req |=>
        (serial_port1_level_out[0] == $past(sfr_wdata_in[`XPRIO_BIT_SER1]));
  endproperty
  a_ser1_lsb_write: assert property (p_ser1_lsb_write)
    else $error("serial port 1 level LSB not written");

  property p_clu0_msb_write;
    @(posedge clk_in) disable iff (rst_in)
      s_high_wr_req |=>
        (logic_unit0_level_out[1] == $past(sfr_wdata_in[`XPRIO_BIT_CLU0]));
  endproperty
  a_clu0_msb_write: assert property (p_clu0_msb_write)
    else $error("logic unit level MSB not written");
endmodule // xprio_regs

/* xprio_regs_bench.sv */
// Self-checking bench for the extended interrupt priority register pair.
// Assumes xprio_pkg is compiled first; the bench drives all ports itself.
module xprio_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import xprio_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] page = 8'h00;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, lo_out, hi_out, rd_val;
  logic hit, hit_val;
  logic [1:0] lv_clu, lv_t5, lv_t4, lv_tw, lv_s1;
  int errors = 0;
  int check_count = 0;
  logic [7:0] lo_t [5] = '{8'hff, 8'h00, 8'h15, 8'h0a, 8'he5};
  logic [7:0] hi_t [5] = '{8'h00, 8'hff, 8'h0a, 8'h15, 8'hf3};

  xprio_regs u_xprio_regs (
    .clk_in(clk_in), .rst_in(rst_in), .sfr_page_in(page),
    .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_rd_in(rd),
    .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .sfr_hit_out(hit),
    .irq_priority_low_bits_2_out(lo_out),
    .irq_priority_high_bits_2_out(hi_out),
    .logic_unit0_level_out(lv_clu), .timer5_level_out(lv_t5),
    .timer4_level_out(lv_t4), .twowire_slave_level_out(lv_tw),
    .serial_port1_level_out(lv_s1)
  );

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One strobe cycle, then one idle edge before the next request
  task automatic wr_reg(input logic [7:0] pg, ad, d, input logic both);
    page <= pg;
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    rd <= both;
    @(posedge clk_in);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd_reg(input logic [7:0] pg, ad);
    page <= pg;
    addr <= ad;
    rd <= 1'b1;
    @(posedge clk_in);
    hit_val = hit;
    rd <= 1'b0;
    @(posedge clk_in);
    rd_val = rdata;
  endtask

  // Write strobe, then a read of the same register on the next edge
  task automatic wr_rd_reg(input logic [7:0] ad, d);
    page <= 8'h10;
    addr <= ad;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    @(posedge clk_in);
    rd_val = rdata;
  endtask

  task automatic chk_all(input logic [7:0] lo, hi);
    check(lo_out, lo);
    check(hi_out, hi);
    check({6'h00, lv_clu}, {6'h00, hi[4], lo[4]});
    check({6'h00, lv_t5}, {6'h00, hi[3], lo[3]});
    check({6'h00, lv_t4}, {6'h00, hi[2], lo[2]});
    check({6'h00, lv_tw}, {6'h00, hi[1], lo[1]});
    check({6'h00, lv_s1}, {6'h00, hi[0], lo[0]});
    rd_reg(8'h10, 8'hed);
    check(rd_val, lo);
    check({7'h00, hit_val}, 8'h01);
    rd_reg(8'h10, 8'hf6);
    check(rd_val, hi);
  endtask

  initial begin
    repeat (5000) @(posedge clk_in);
    errors++;
    $display("mismatch at %0t: run did not finish", $time);
    complete_run();
  end

  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    chk_all(8'h00, 8'h00);
    // Reserved bits written high must read back as zero
    for (int i = 0; i < 5; i++) begin
      wr_reg(8'h10, 8'hed, lo_t[i], 1'b0);
      wr_reg(8'h10, 8'hf6, hi_t[i], 1'b0);
      chk_all(lo_t[i] & 8'h1f, hi_t[i] & 8'h1f);
    end
    // Wrong page, unmapped address and write-with-read are ignored
    wr_reg(8'h00, 8'hed, 8'h00, 1'b0);
    wr_reg(8'h10, 8'hee, 8'h00, 1'b0);
    wr_reg(8'h10, 8'hf6, 8'h00, 1'b1);
    chk_all(8'h05, 8'h13);
    rd_reg(8'h00, 8'hed);
    check(rd_val, 8'h00);
    check({7'h00, hit_val}, 8'h00);
    rd_reg(8'h10, 8'hf5);
    check(rd_val, 8'h00);
    // Back-to-back write and read of each register
    wr_rd_reg(8'hed, 8'hff);
    check(rd_val, 8'h1f);
    wr_rd_reg(8'hf6, 8'hea);
    check(rd_val, 8'h0a);
    // Reset in mid-run clears both registers
    rst_in <= 1'b1;
    @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    check(rdata, 8'h00);
    chk_all(8'h00, 8'h00);
    complete_run();
  end
endmodule // xprio_regs_bench
